// >>> main_adc_defs.svh
// Purpose: shared constants of the main converter sequencer
// Assumes: one clock at 250 MHz
// Notes:   slot map and timing counts live here as macros
`ifndef MAIN_ADC_DEFS_SVH
`define MAIN_ADC_DEFS_SVH

`define CLK_PERIOD_PS     4000
`define SLOT_TIME_NS      8000
`define PASS_TIME_NS      192000
`define SLOT_CYCLES       ((`SLOT_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define DELAY_STEP_NS     1000
`define DELAY_STEP_CYCLES ((`DELAY_STEP_NS * 1000) / `CLK_PERIOD_PS)

`define NUM_SLOTS         24
`define SLOT_DIE_TEMP     5'h00
`define SLOT_THERM_REF    5'h01
`define SLOT_SENSE_FIRST  5'h02
`define SLOT_SENSE_LAST   5'h11
`define SLOT_REDUNDANT    5'h12
`define SLOT_GPIO         5'h13
`define SLOT_LAST         5'h17
`define NUM_SENSE         16
`define NUM_GPIO          8
`define NUM_ENTRIES       27
`define ENTRY_GPIO_FIRST  5'h13
`define NUM_FILTERED      17

`define RESULT_DEFAULT    16'h8000
`define PASSES_FOR_READY  4'h8

`endif

// >>> main_adc_pkg.sv
// Purpose: types of the main converter sequencer
// Assumes: nothing
// Notes:   constants sit in main_adc_defs.svh
package main_adc_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b001,
    SEQ_DELAY   = 3'b010,
    SEQ_CONVERT = 3'b100
  } seq_state_t;

  typedef logic [15:0] sample_t;

endpackage : main_adc_pkg

// >>> lpf_if.sv
// Purpose: carries samples between sequencer and low-pass filter
// Assumes: one clock domain
// Notes:   result comes one cycle after sample
`timescale 1ns/1ps
interface lpf_if;
  import main_adc_pkg::*;
  logic       sampleValid;
  logic [4:0] sampleIndex;
  sample_t    sampleData;
  logic       restart;
  logic       filtEnSense;
  logic       filtEnRedundant;
  logic [2:0] shiftSense;
  logic [2:0] shiftRedundant;
  logic       resultValid;
  logic [4:0] resultIndex;
  sample_t    resultData;

  modport seq  (output sampleValid, sampleIndex, sampleData, restart, filtEnSense,
                filtEnRedundant, shiftSense, shiftRedundant,
                input resultValid, resultIndex, resultData);
  modport filt (input sampleValid, sampleIndex, sampleData, restart, filtEnSense,
                filtEnRedundant, shiftSense, shiftRedundant,
                output resultValid, resultIndex, resultData);
endinterface : lpf_if

// >>> sense_lowpass_filter.sv
// Purpose: single-pole low-pass per sense channel and on the redundant slot, pass-through otherwise
// Assumes: shift code 0..6 gives coefficient 1/2 .. 1/128
// Notes:   first sample after restart loads the state directly
`timescale 1ns/1ps
`include "main_adc_defs.svh"
module sense_lowpass_filter
  import main_adc_pkg::*;
(
  input  wire logic clk,    // core clock
  input  wire logic reset,  // async reset, active high
  lpf_if.filt       lp      // sample in, result out
);

  sample_t                   acc      [`NUM_FILTERED];
  sample_t                   next_acc [`NUM_FILTERED];
  logic [`NUM_FILTERED-1:0]  primed;
  logic [`NUM_FILTERED-1:0]  next_primed;
  logic                      next_valid;
  logic [4:0]                next_index;
  sample_t                   next_data;

  logic [4:0]  ch;
  logic        isFiltered;
  logic [2:0]  shiftSel;
  logic [16:0] diff;
  sample_t     step;

  always_comb begin
    ch         = lp.sampleIndex - `SLOT_SENSE_FIRST;
    isFiltered = 1'b0;
    shiftSel   = lp.shiftSense;
    if (lp.sampleIndex >= `SLOT_SENSE_FIRST && lp.sampleIndex <= `SLOT_SENSE_LAST) begin
      isFiltered = lp.filtEnSense;
    end else if (lp.sampleIndex == `SLOT_REDUNDANT) begin
      isFiltered = lp.filtEnRedundant;
      shiftSel   = lp.shiftRedundant;
    end
    diff = {lp.sampleData[15], lp.sampleData} - {acc[ch][15], acc[ch]};
    step = 16'(17'($signed(diff) >>> (shiftSel + 3'd1)));
    next_acc    = acc;
    next_primed = lp.restart ? '0 : primed;
    next_valid  = lp.sampleValid;
    next_index  = lp.sampleIndex;
    next_data   = lp.sampleData;
    if (lp.sampleValid && isFiltered) begin
      if (!primed[ch]) begin
        next_acc[ch] = lp.sampleData;  // jump to first value, fast settling
      end else begin
        next_acc[ch] = acc[ch] + step;
      end
      next_primed[ch] = 1'b1;
      next_data       = next_acc[ch];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `NUM_FILTERED; i++) acc[i] <= 16'h0000;
      primed         <= '0;
      lp.resultValid <= 1'b0;
      lp.resultIndex <= 5'h00;
      lp.resultData  <= 16'h0000;
    end else begin
      acc            <= next_acc;
      primed         <= next_primed;
      lp.resultValid <= next_valid;
      lp.resultIndex <= next_index;
      lp.resultData  <= next_data;
    end
  end

  a_filter_latency: assert property (@(posedge clk) disable iff (reset)
    lp.sampleValid |=> lp.resultValid && lp.resultIndex == $past(lp.sampleIndex))
    else $error("filter result not one cycle after sample");

endmodule : sense_lowpass_filter

// >>> main_adc_round_robin_sequencer.sv
// Purpose: round-robin sequencer and result byte pairs of the main converter
// Assumes: all inputs come from logic on clk
// Notes:   results read by index, one byte per strobe
`timescale 1ns/1ps
`include "main_adc_defs.svh"
module main_adc_round_robin_sequencer
  import main_adc_pkg::*;
(
  input  wire logic        clk,             // core clock, 250 MHz
  input  wire logic        reset,           // async reset, active high
  input  wire logic        hwReset,         // host hardware reset request, level
  input  wire logic        powerActive,     // high in active power mode
  input  wire logic        mainEnable,      // main converter enable
  input  wire logic        goCmd,           // conversion go, one-cycle pulse
  input  wire logic [7:0]  gpioActiveMask,  // one bit per gpio input
  input  wire logic        filtEnSense,     // low-pass on sense slots
  input  wire logic        filtEnRedundant, // low-pass on redundant current slot
  input  wire logic [2:0]  shiftSense,      // sense filter coefficient code
  input  wire logic [2:0]  shiftRedundant,  // redundant filter coefficient code
  input  wire logic [5:0]  startDelay,      // start delay in 1 us steps
  input  wire logic        adcDone,         // conversion complete, pulse
  input  wire sample_t     adcData,         // conversion result, signed
  input  wire logic        rdStrobe,        // result byte read, pulse
  input  wire logic [4:0]  rdIndex,         // result entry index
  input  wire logic        rdHigh,          // 1 high byte, 0 low byte
  output logic [7:0]       rdData,          // read byte, next cycle
  output logic             convStart,       // slot conversion start, pulse
  output logic [4:0]       muxSlot,         // slot on the input multiplexer
  output logic [2:0]       gpioSel,         // gpio on the shared slot
  output logic             running,         // sequencer running
  output logic             resultsReady     // eight passes done
);

  localparam logic [15:0] SLOT_END = 16'(`SLOT_CYCLES - 1);

  lpf_if lp ();

  sense_lowpass_filter u_filter (
    .clk   (clk),
    .reset (reset),
    .lp    (lp)
  );

  // ---------------- sequencer ----------------
  seq_state_t  state, next_state;
  logic [4:0]  slot, next_slot;
  logic [15:0] cnt, next_cnt;
  logic [3:0]  passCnt, next_passCnt;
  logic [2:0]  gpioPtr, next_gpioPtr;
  logic [7:0]  cfgMask, next_cfgMask;
  logic        cfgFs, next_cfgFs, cfgFr, next_cfgFr;
  logic [2:0]  cfgSs, next_cfgSs, cfgSr, next_cfgSr;
  logic        next_convStart, next_running, next_resultsReady;
  logic        goTaken, loadDefaults, slotUsed, wrap, slotEnd;

  function automatic logic used(input logic [4:0] s, input logic [2:0] p,
                                input logic [7:0] m);
    if (s > `SLOT_GPIO) return 1'b0;  // spares are skipped
    if (s == `SLOT_GPIO) return m[p];
    return 1'b1;
  endfunction : used

  always_comb begin
    goTaken        = goCmd && mainEnable && powerActive;
    loadDefaults   = goTaken || hwReset;
    slotUsed       = used(slot, gpioPtr, cfgMask);
    slotEnd        = state == SEQ_CONVERT && cnt == SLOT_END;
    wrap           = slotEnd && slot == `SLOT_LAST;
    next_state     = state;
    next_slot      = slot;
    next_cnt       = cnt;
    next_passCnt   = passCnt;
    next_gpioPtr   = gpioPtr;
    next_cfgMask   = cfgMask;
    next_cfgFs     = cfgFs;
    next_cfgFr     = cfgFr;
    next_cfgSs     = cfgSs;
    next_cfgSr     = cfgSr;
    next_convStart = 1'b0;
    next_resultsReady = resultsReady;
    case (state)
      SEQ_DELAY: begin
        if (cnt == 16'h0000) begin
          next_state     = SEQ_CONVERT;
          next_slot      = `SLOT_DIE_TEMP;
          next_convStart = 1'b1;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      SEQ_CONVERT: begin
        if (slotEnd) begin
          next_cnt  = 16'h0000;
          next_slot = wrap ? `SLOT_DIE_TEMP : slot + 5'h01;
          if (wrap) begin
            next_gpioPtr = gpioPtr + 3'h1;
            if (passCnt != `PASSES_FOR_READY) next_passCnt = passCnt + 4'h1;
          end
          next_convStart = used(next_slot, next_gpioPtr, cfgMask);
        end else begin
          next_cnt = cnt + 16'h0001;
        end
        if (next_passCnt == `PASSES_FOR_READY) next_resultsReady = 1'b1;
      end
      SEQ_IDLE: begin
      end
      default: next_state = SEQ_IDLE;
    endcase
    if (goTaken) begin
      next_state   = SEQ_DELAY;
      next_cnt     = 16'(startDelay * `DELAY_STEP_CYCLES);
      next_slot    = `SLOT_DIE_TEMP;
      next_passCnt = 4'h0;
      next_gpioPtr = 3'h0;
      next_cfgMask = gpioActiveMask;
      next_cfgFs   = filtEnSense;
      next_cfgFr   = filtEnRedundant;
      next_cfgSs   = shiftSense;
      next_cfgSr   = shiftRedundant;
      next_convStart    = 1'b0;
      next_resultsReady = 1'b0;
    end
    if (!mainEnable || !powerActive || hwReset) begin
      next_state     = SEQ_IDLE;
      next_convStart = 1'b0;
    end
    if (hwReset) begin
      next_slot    = 5'h00;
      next_cnt     = 16'h0000;
      next_passCnt = 4'h0;
      next_gpioPtr = 3'h0;
      next_cfgMask = 8'h00;
      next_cfgFs   = 1'b0;
      next_cfgFr   = 1'b0;
      next_cfgSs   = 3'h0;
      next_cfgSr   = 3'h0;
      next_resultsReady = 1'b0;
    end
    next_running = next_state != SEQ_IDLE;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state        <= SEQ_IDLE;
      slot         <= 5'h00;
      cnt          <= 16'h0000;
      passCnt      <= 4'h0;
      gpioPtr      <= 3'h0;
      cfgMask      <= 8'h00;
      cfgFs        <= 1'b0;
      cfgFr        <= 1'b0;
      cfgSs        <= 3'h0;
      cfgSr        <= 3'h0;
      convStart    <= 1'b0;
      running      <= 1'b0;
      resultsReady <= 1'b0;
      muxSlot      <= 5'h00;
      gpioSel      <= 3'h0;
    end else begin
      state        <= next_state;
      slot         <= next_slot;
      cnt          <= next_cnt;
      passCnt      <= next_passCnt;
      gpioPtr      <= next_gpioPtr;
      cfgMask      <= next_cfgMask;
      cfgFs        <= next_cfgFs;
      cfgFr        <= next_cfgFr;
      cfgSs        <= next_cfgSs;
      cfgSr        <= next_cfgSr;
      convStart    <= next_convStart;
      running      <= next_running;
      resultsReady <= next_resultsReady;
      muxSlot      <= next_slot;
      gpioSel      <= next_gpioPtr;
    end
  end

  // samples of spare or inactive slots never reach the filter
  always_comb begin
    lp.sampleValid     = adcDone && state == SEQ_CONVERT && slotUsed && !loadDefaults;
    lp.sampleIndex     = (slot == `SLOT_GPIO) ? `ENTRY_GPIO_FIRST + 5'(gpioPtr) : slot;
    lp.sampleData      = adcData;
    lp.restart         = loadDefaults;
    lp.filtEnSense     = cfgFs;
    lp.filtEnRedundant = cfgFr;
    lp.shiftSense      = cfgSs;
    lp.shiftRedundant  = cfgSr;
  end

  // ---------------- result pairs ----------------
  logic [7:0]              hiByte      [`NUM_ENTRIES];
  logic [7:0]              loByte      [`NUM_ENTRIES];
  logic [7:0]              next_hiByte [`NUM_ENTRIES];
  logic [7:0]              next_loByte [`NUM_ENTRIES];
  logic [`NUM_ENTRIES-1:0] frozen, next_frozen;
  logic [7:0]              next_rdData;
  logic                    rdOk;

  always_comb begin
    next_hiByte = hiByte;
    next_loByte = loByte;
    next_frozen = frozen;
    next_rdData = rdData;
    rdOk        = rdStrobe && rdIndex < 5'(`NUM_ENTRIES);
    if (loadDefaults) begin
      for (int i = 0; i < `NUM_ENTRIES; i++) begin
        next_hiByte[i] = 8'(`RESULT_DEFAULT >> 8);
        next_loByte[i] = 8'(`RESULT_DEFAULT);
      end
      next_frozen = '0;
    end else begin
      if (lp.resultValid) begin
        next_hiByte[lp.resultIndex] = lp.resultData[15:8];
        // high byte just read or still pending keeps its low partner
        if (!frozen[lp.resultIndex] && !(rdOk && rdHigh && rdIndex == lp.resultIndex))
          next_loByte[lp.resultIndex] = lp.resultData[7:0];
      end
      if (rdOk) begin
        next_frozen[rdIndex] = rdHigh;
      end
    end
    if (rdOk) next_rdData = rdHigh ? hiByte[rdIndex] : loByte[rdIndex];
    else if (rdStrobe) next_rdData = 8'h00;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `NUM_ENTRIES; i++) begin
        hiByte[i] <= 8'(`RESULT_DEFAULT >> 8);
        loByte[i] <= 8'(`RESULT_DEFAULT);
      end
      frozen <= '0;
      rdData <= 8'h00;
    end else begin
      hiByte <= next_hiByte;
      loByte <= next_loByte;
      frozen <= next_frozen;
      rdData <= next_rdData;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_slot_wrap: assert property (wrap && !loadDefaults && mainEnable && powerActive
    |=> slot == 5'h00 && passCnt != 4'h0) else $error("pass did not wrap to slot zero");
  a_slot_time: assert property (state == SEQ_CONVERT |-> cnt <= SLOT_END)
    else $error("slot counter past slot length");
  a_go_defaults: assert property (goTaken |=> hiByte[0] == 8'h80 && loByte[19] == 8'h00)
    else $error("results not forced to default on go");
  a_low_frozen: assert property (frozen[0] && !loadDefaults && !(rdOk && rdIndex == 5'h00)
    |=> $stable(loByte[0])) else $error("frozen low byte changed");
  a_gpio_advance: assert property (wrap && !loadDefaults && mainEnable && powerActive
    |=> gpioPtr == 3'($past(gpioPtr) + 3'h1)) else $error("gpio pointer did not advance");
  a_ready_rise: assert property ($rose(resultsReady) |-> passCnt == 4'h8)
    else $error("ready without eight passes");
  a_stop_sleep: assert property (!powerActive |=> !running ##1 !convStart)
    else $error("sequencer ran outside active mode");
  a_hw_reset: assert property (hwReset |=> state == SEQ_IDLE && !resultsReady
    && hiByte[5] == 8'h80) else $error("hardware reset did not restore state");
  a_inactive_gpio: assert property (convStart && muxSlot == `SLOT_GPIO
    |-> cfgMask[gpioSel]) else $error("inactive gpio converted");

endmodule : main_adc_round_robin_sequencer

// >>> tb_top.sv
// Purpose: self-checking bench for the main converter round-robin sequencer
// Assumes: inputs change on the falling edge, outputs settled there
// Notes:   8-pass ready flag too long to reach here
`timescale 1ns/1ps
module tb_top;
  import main_adc_pkg::*;
  logic        clk             = 1'b0;
  logic        reset           = 1'b1;
  logic        hwReset         = 1'b0;
  logic        powerActive     = 1'b1;
  logic        mainEnable      = 1'b1;
  logic        goCmd           = 1'b0;
  logic [7:0]  gpioActiveMask  = 8'h00;
  logic [5:0]  startDelay      = 6'h00;
  logic        filtEnSense     = 1'b0;
  logic        filtEnRedundant = 1'b0;
  logic [2:0]  shiftSense      = 3'h0;
  logic [2:0]  shiftRedundant  = 3'h0;
  logic        adcDone         = 1'b0;
  sample_t     adcData         = 16'h0000;
  logic        rdStrobe        = 1'b0;
  logic [4:0]  rdIndex         = 5'h00;
  logic        rdHigh          = 1'b0;
  logic [7:0]  rdData;
  logic        convStart;
  logic [4:0]  muxSlot;
  logic [2:0]  gpioSel;
  logic        running;
  logic        resultsReady;
  int          failures        = 0;
  int          n_checks        = 0;
  int          cyc             = 0;
  int          t0;
  int          last;

  always #2 clk = ~clk;
  always @(negedge clk) cyc <= cyc + 1;

  main_adc_round_robin_sequencer dut (
    .clk(clk), .reset(reset), .hwReset(hwReset), .powerActive(powerActive),
    .mainEnable(mainEnable), .goCmd(goCmd), .gpioActiveMask(gpioActiveMask),
    .filtEnSense(filtEnSense), .filtEnRedundant(filtEnRedundant), .shiftSense(shiftSense),
    .shiftRedundant(shiftRedundant), .startDelay(startDelay), .adcDone(adcDone),
    .adcData(adcData), .rdStrobe(rdStrobe), .rdIndex(rdIndex), .rdHigh(rdHigh),
    .rdData(rdData), .convStart(convStart), .muxSlot(muxSlot), .gpioSel(gpioSel),
    .running(running), .resultsReady(resultsReady)
  );

  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // distinct negative codes per slot, never the default pattern
  function automatic logic [15:0] dval(input int s);
    return 16'h8001 + 16'h0101 * s[15:0];
  endfunction : dval

  task rd(input logic [4:0] idx, input logic hi, output logic [7:0] d);
    @(negedge clk);
    rdStrobe = 1'b1;
    rdIndex  = idx;
    rdHigh   = hi;
    @(negedge clk);
    rdStrobe = 1'b0;
    d = rdData;
  endtask : rd

  // high first, then low, so the pair stays coherent
  task rdpair(input logic [4:0] idx, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(idx, 1'b1, h);
    rd(idx, 1'b0, l);
    v = {h, l};
  endtask : rdpair

  task wait_conv(input int lim);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (k > lim) begin
        $display("wait for slot start timed out");
        failures++;
        print_verdict();
      end
    end while (convStart !== 1'b1);
  endtask : wait_conv

  task go(input logic [5:0] dly);
    startDelay = dly;
    @(negedge clk);
    goCmd = 1'b1;
    t0 = cyc;
    @(negedge clk);
    goCmd = 1'b0;
  endtask : go

  task feed(input logic [15:0] v);
    adcDone = 1'b1;
    adcData = v;
    @(negedge clk);
    adcDone = 1'b0;
  endtask : feed

  task t_reset;
    logic [15:0] v;
    check({11'h0, convStart, running, resultsReady, 2'b00}, 16'h0000);
    rdpair(5'h00, v);
    check(v, 16'h8000);
    rdpair(5'h1A, v);
    check(v, 16'h8000);
    $display("test reset done");
  endtask : t_reset

  task t_pass;
    logic [15:0] v;
    logic [7:0]  b;
    gpioActiveMask  = 8'hFE;
    filtEnSense     = 1'b1;
    filtEnRedundant = 1'b1;
    go(6'h01);
    filtEnSense     = 1'b0;  // taken at go, must not reach the filter
    check({15'h0, running}, 16'h0001);
    for (int s = 0; s < 19; s++) begin
      wait_conv(s == 0 ? 300 : 2100);
      if (s == 0)
        check(cyc - t0, 252);
      else
        check(cyc - last, 2000);
      check({11'h0, muxSlot}, s);
      last = cyc;
      feed(dval(s));
      repeat (3) @(negedge clk);
      rdpair(s[4:0], v);
      check(v, dval(s));
    end
    rdpair(5'h13, v);
    check(v, 16'h8000);
    rd(5'h00, 1'b1, b);
    // slots 19..23 idle: gpio 0 inactive, spares never start
    wait_conv(12100);
    check(cyc - last, 12000);
    check({11'h0, muxSlot}, 16'h0000);
    check({13'h0, gpioSel}, 16'h0001);
    check({15'h0, resultsReady}, 16'h0000);
    feed(16'h5A6B);
    repeat (3) @(negedge clk);
    rd(5'h00, 1'b1, b);
    check({8'h0, b}, 16'h005A);
    rd(5'h00, 1'b0, b);
    check({8'h0, b}, 16'h0001);
    rd(5'h00, 1'b0, b);
    check({8'h0, b}, 16'h0001);
    // second sense sample of slot 2 lands halfway from 8203 to 0203
    wait_conv(2100);
    wait_conv(2100);
    check({11'h0, muxSlot}, 16'h0002);
    feed(16'h0203);
    repeat (3) @(negedge clk);
    rdpair(5'h02, v);
    check(v, 16'hC203);
    $display("test pass done");
  endtask : t_pass

  task t_stop;
    int n;
    @(negedge clk);
    powerActive = 1'b0;
    @(negedge clk);
    check({15'h0, running}, 16'h0000);
    n = 0;
    repeat (2500) begin
      @(negedge clk);
      if (convStart !== 1'b0) n++;
    end
    check(n, 0);
    go(6'h00);
    check({15'h0, running}, 16'h0000);
    powerActive = 1'b1;
    mainEnable  = 1'b0;
    go(6'h00);
    check({15'h0, running}, 16'h0000);
    mainEnable = 1'b1;
    $display("test stop done");
  endtask : t_stop

  task t_restart;
    logic [15:0] v;
    logic [7:0]  b;
    go(6'h00);
    check({15'h0, running}, 16'h0001);
    wait_conv(10);
    check(cyc - t0, 2);
    feed(16'h0000);
    rdpair(5'h01, v);
    check(v, 16'h8000);
    rdpair(5'h00, v);
    check(v, 16'h0000);
    @(negedge clk);
    hwReset = 1'b1;
    @(negedge clk);
    hwReset = 1'b0;
    check({15'h0, running}, 16'h0000);
    rdpair(5'h00, v);
    check(v, 16'h8000);
    rd(5'h1B, 1'b1, b);
    check({8'h0, b}, 16'h0000);
    $display("test restart done");
  endtask : t_restart

  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_pass();
    t_stop();
    t_restart();
    print_verdict();
  end
endmodule : tb_top
